// *** src/tlip_params.svh ***
`ifndef TLIP_PARAMS_SVH
`define TLIP_PARAMS_SVH

// Special-function addresses of the three configuration registers
`define TLIP_ADDR_ENABLE 8'ha8
`define TLIP_ADDR_LEVEL  8'hb8
`define TLIP_ADDR_AUX    8'ha9

// Reset values
`define TLIP_RST_ENABLE 8'h00
`define TLIP_RST_LEVEL  8'h00
`define TLIP_RST_AUX    8'ha0

// Enable register fields
`define TLIP_EN_GATE_BIT 7
`define TLIP_EN_CONV_BIT 6
`define TLIP_EN_T2_BIT   5
`define TLIP_EN_UART_BIT 4
`define TLIP_EN_T1_BIT   3
`define TLIP_EN_X1_BIT   2
`define TLIP_EN_T0_BIT   1
`define TLIP_EN_X0_BIT   0

// Aux register fields
`define TLIP_AUX_LVL_TIC_BIT  6
`define TLIP_AUX_LVL_PSM_BIT  5
`define TLIP_AUX_LVL_SER_BIT  4
`define TLIP_AUX_ZERO_BIT     3
`define TLIP_AUX_EN_TIC_BIT   2
`define TLIP_AUX_EN_PSM_BIT   1
`define TLIP_AUX_EN_SER_BIT   0
`define TLIP_AUX_WMASK        8'h77

// Level register writable bits (bit 7 reserved)
`define TLIP_LVL_WMASK        8'h7f

// Vector addresses, indexed by polling rank
`define TLIP_VEC_PSM   16'h0043
`define TLIP_VEC_WDOG  16'h005b
`define TLIP_VEC_X0    16'h0003
`define TLIP_VEC_CONV  16'h0033
`define TLIP_VEC_T0    16'h000b
`define TLIP_VEC_X1    16'h0013
`define TLIP_VEC_T1    16'h001b
`define TLIP_VEC_SER   16'h003b
`define TLIP_VEC_UART  16'h0023
`define TLIP_VEC_T2    16'h002b
`define TLIP_VEC_TIC   16'h0053

`define TLIP_NSRC 11

`endif

// *** src/tlip_pkg.sv ***
package tlip_pkg;

	// Raw request flags from the peripherals
	typedef struct packed {
		logic supply_monitor_flag;
		logic watchdog_timeout_flag;
		logic ext_int0_flag;
		logic main_conv_ready;
		logic aux_conv_ready;
		logic timer0_overflow;
		logic ext_int1_flag;
		logic timer1_overflow;
		logic twowire_int_flag;
		logic serial_periph_int_flag;
		logic uart_receive_done;
		logic uart_transmit_done;
		logic timer2_overflow;
		logic timer2_external_flag;
		logic interval_counter_flag;
	} tlip_req_s;

	// Special-function register write port
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} tlip_sfr_wr_s;

	typedef enum logic [2:0] {
		TLIP_IDLE = 3'b001,
		TLIP_PUSH = 3'b010,
		TLIP_LOAD = 3'b100
	} tlip_state_e;

endpackage : tlip_pkg

// *** src/tlip_prioritizer.sv ***
// How it works
// (RULE_01) High request preempts low-level service routine
// (RULE_02) Simultaneous levels: high dispatched before low
// (RULE_03) Same level cannot preempt active routine
// (RULE_04) Poll order: supply, watchdog, ext0, converter, timer0, ext1
// (RULE_05) Then timer1, serial, uart, timer2, interval counter
// (RULE_06) Push program counter before entering routine
// (RULE_07) Vectors 03,0B,13,1B,23,2B for core sources
// (RULE_08) Vectors 33,3B,43,53,5B; shared vectors
// (RULE_09) Watchdog interrupts when select bit set
// (RULE_10) Watchdog request always high level
// (RULE_11) Global gate never masks watchdog
// (RULE_12) Watchdog interrupts only with nonzero timeout
// (RULE_13) Per-source enable and two-level select
// (RULE_14) Enable register A8, reset 00, bit7 gate
// (RULE_15) Level register B8, reset 00, one=high
// (RULE_16) Aux register A9, reset A0, bit3 zero
// (RULE_17) Return instruction releases the exited level
// (RULE_18) Maskable source needs own and global enable
`timescale 1ns/1ps
`include "tlip_params.svh"

module tlip_prioritizer (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// Request flags, already in the core clock domain
	input  wire tlip_pkg::tlip_req_s   req_i,
	input  wire logic                  watchdog_irq_select_i,
	input  wire logic                  watchdog_timeout_nz_i,
	// Register writes from the core
	input  wire tlip_pkg::tlip_sfr_wr_s sfr_wr_i,
	// Core handshake
	input  wire logic                  core_ack_i,
	input  wire logic                  reti_i,
	input  wire logic [15:0]           pc_i,
	// Outputs to the core
	output logic                       push_o,
	output logic [15:0]                push_pc_o,
	output logic                       vector_load_o,
	output logic [15:0]                vector_o,
	output logic [3:0]                 src_rank_o,
	output logic                       active_high_o,
	output logic                       active_low_o,
	output logic [7:0]                 irq_enable_reg_o,
	output logic [7:0]                 irq_level_reg_o,
	output logic [7:0]                 aux_irq_reg_o
);

	localparam int NSRC = `TLIP_NSRC;

	logic [7:0]           irq_enable_reg;
	logic [7:0]           irq_level_reg;
	logic [7:0]           aux_irq_reg;
	logic                 act_hi;
	logic                 act_lo;
	tlip_pkg::tlip_state_e state;
	logic [NSRC-1:0]      raw;
	logic [NSRC-1:0]      en;
	logic [NSRC-1:0]      lvl;
	logic [NSRC-1:0]      elig_hi;
	logic [NSRC-1:0]      elig_lo;
	logic                 pick_valid;
	logic                 pick_hi;
	logic [3:0]           pick_rank;
	logic                 global_irq_gate;

	// Lowest index wins, index 0 is the top polling rank
	function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
		logic [3:0] r;
		r = 4'hf;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : first_set

	function automatic logic [15:0] vec_of(input logic [3:0] r);
		logic [15:0] v;
		case (r)
			4'h0:    v = `TLIP_VEC_PSM;
			4'h1:    v = `TLIP_VEC_WDOG;
			4'h2:    v = `TLIP_VEC_X0;
			4'h3:    v = `TLIP_VEC_CONV;
			4'h4:    v = `TLIP_VEC_T0;
			4'h5:    v = `TLIP_VEC_X1;
			4'h6:    v = `TLIP_VEC_T1;
			4'h7:    v = `TLIP_VEC_SER;
			4'h8:    v = `TLIP_VEC_UART;
			4'h9:    v = `TLIP_VEC_T2;
			default: v = `TLIP_VEC_TIC;
		endcase
		return v;
	endfunction : vec_of

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_enable_reg <= `TLIP_RST_ENABLE; // see RULE_14
			irq_level_reg  <= `TLIP_RST_LEVEL; // see RULE_15
			aux_irq_reg    <= `TLIP_RST_AUX; // see RULE_16
		end else if (sfr_wr_i.we) begin
			case (sfr_wr_i.addr)
				`TLIP_ADDR_ENABLE: irq_enable_reg <= sfr_wr_i.data; // see RULE_13
				`TLIP_ADDR_LEVEL:  irq_level_reg  <= sfr_wr_i.data & `TLIP_LVL_WMASK;
				// Reserved top bit keeps its reset one, bit 3 is forced to zero
				`TLIP_ADDR_AUX:    aux_irq_reg <= (sfr_wr_i.data & `TLIP_AUX_WMASK)
				                                  | (`TLIP_RST_AUX & ~`TLIP_AUX_WMASK); // see RULE_16
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Request gating, in polling-rank order
	// ------------------------------------------------------------
	assign global_irq_gate = irq_enable_reg[`TLIP_EN_GATE_BIT];

	always_comb begin
		raw = {req_i.interval_counter_flag,
		       req_i.timer2_overflow | req_i.timer2_external_flag,
		       req_i.uart_receive_done | req_i.uart_transmit_done,
		       req_i.twowire_int_flag | req_i.serial_periph_int_flag,
		       req_i.timer1_overflow,
		       req_i.ext_int1_flag,
		       req_i.timer0_overflow,
		       req_i.main_conv_ready | req_i.aux_conv_ready,
		       req_i.ext_int0_flag,
		       req_i.watchdog_timeout_flag & watchdog_irq_select_i
		         & watchdog_timeout_nz_i, // see RULE_09 see RULE_12
		       req_i.supply_monitor_flag}; // see RULE_04 see RULE_05 see RULE_08
		en  = {aux_irq_reg[`TLIP_AUX_EN_TIC_BIT],
		       irq_enable_reg[`TLIP_EN_T2_BIT],
		       irq_enable_reg[`TLIP_EN_UART_BIT],
		       aux_irq_reg[`TLIP_AUX_EN_SER_BIT],
		       irq_enable_reg[`TLIP_EN_T1_BIT],
		       irq_enable_reg[`TLIP_EN_X1_BIT],
		       irq_enable_reg[`TLIP_EN_T0_BIT],
		       irq_enable_reg[`TLIP_EN_CONV_BIT],
		       irq_enable_reg[`TLIP_EN_X0_BIT],
		       1'b1,
		       aux_irq_reg[`TLIP_AUX_EN_PSM_BIT]};
		lvl = {aux_irq_reg[`TLIP_AUX_LVL_TIC_BIT],
		       irq_level_reg[`TLIP_EN_T2_BIT],
		       irq_level_reg[`TLIP_EN_UART_BIT],
		       aux_irq_reg[`TLIP_AUX_LVL_SER_BIT],
		       irq_level_reg[`TLIP_EN_T1_BIT],
		       irq_level_reg[`TLIP_EN_X1_BIT],
		       irq_level_reg[`TLIP_EN_T0_BIT],
		       irq_level_reg[`TLIP_EN_CONV_BIT],
		       irq_level_reg[`TLIP_EN_X0_BIT],
		       1'b1, // see RULE_10
		       aux_irq_reg[`TLIP_AUX_LVL_PSM_BIT]};
		// Watchdog (rank 1) bypasses both enables
		for (int i = 0; i < NSRC; i++) begin
			if (i == 1) begin
				en[i] = 1'b1; // see RULE_11
			end else begin
				en[i] = en[i] & global_irq_gate; // see RULE_18
			end
		end
		elig_hi = raw & en & lvl & {NSRC{~act_hi}}; // see RULE_03
		elig_lo = raw & en & ~lvl & {NSRC{~act_hi & ~act_lo}}; // see RULE_01 see RULE_03
		pick_hi = |elig_hi; // see RULE_02
		pick_valid = pick_hi | (|elig_lo);
		pick_rank = pick_hi ? first_set(elig_hi) : first_set(elig_lo);
	end

	// ------------------------------------------------------------
	// Dispatch sequencer
	// ------------------------------------------------------------
	// Rank and level are frozen at decision time so a flag that drops
	// during the push still vectors where the push promised.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state         <= tlip_pkg::TLIP_IDLE;
			push_o        <= 1'b0;
			push_pc_o     <= 16'h0000;
			vector_load_o <= 1'b0;
			vector_o      <= 16'h0000;
			src_rank_o    <= 4'h0;
		end else begin
			push_o        <= 1'b0;
			vector_load_o <= 1'b0;
			case (state)
				tlip_pkg::TLIP_IDLE: begin
					if (pick_valid && !reti_i) begin
						state      <= tlip_pkg::TLIP_PUSH;
						push_o     <= 1'b1; // see RULE_06
						push_pc_o  <= pc_i;
						src_rank_o <= pick_rank;
						vector_o   <= vec_of(pick_rank); // see RULE_07 see RULE_08
					end
				end
				tlip_pkg::TLIP_PUSH: begin
					if (core_ack_i) begin
						state         <= tlip_pkg::TLIP_LOAD;
						vector_load_o <= 1'b1; // see RULE_06
					end else begin
						push_o <= 1'b1;
					end
				end
				tlip_pkg::TLIP_LOAD: state <= tlip_pkg::TLIP_IDLE;
				default:             state <= tlip_pkg::TLIP_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Active-level tracking
	// ------------------------------------------------------------
	logic hi_taken;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hi_taken <= 1'b0;
		end else if (state == tlip_pkg::TLIP_IDLE && pick_valid && !reti_i) begin
			hi_taken <= pick_hi;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			act_hi <= 1'b0;
			act_lo <= 1'b0;
		end else if (state == tlip_pkg::TLIP_LOAD) begin
			if (hi_taken) begin
				act_hi <= 1'b1;
			end else begin
				act_lo <= 1'b1;
			end
		end else if (reti_i) begin
			// Release the innermost level only
			if (act_hi) begin
				act_hi <= 1'b0; // see RULE_17
			end else begin
				act_lo <= 1'b0; // see RULE_17
			end
		end
	end

	// ------------------------------------------------------------
	// Registered status outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			active_high_o    <= 1'b0;
			active_low_o     <= 1'b0;
			irq_enable_reg_o <= `TLIP_RST_ENABLE;
			irq_level_reg_o  <= `TLIP_RST_LEVEL;
			aux_irq_reg_o    <= `TLIP_RST_AUX;
		end else begin
			active_high_o    <= act_hi;
			active_low_o     <= act_lo;
			irq_enable_reg_o <= irq_enable_reg;
			irq_level_reg_o  <= irq_level_reg;
			aux_irq_reg_o    <= aux_irq_reg;
		end
	end

endmodule : tlip_prioritizer

// *** testbench/test_tlip_prioritizer.sv ***
`timescale 1ns/1ps
module test_tlip_prioritizer;
	logic                   clk_i = 1'b0;
	logic                   rst_n_i = 1'b0;
	tlip_pkg::tlip_req_s    req = '0;
	tlip_pkg::tlip_sfr_wr_s sfr = '0;
	logic                   wsel = 1'b0;
	logic                   wnz = 1'b0;
	logic                   reti_i = 1'b0;
	logic [3:0]             dly = 4'h0;
	logic                   ack, push, load, act_hi, act_lo;
	logic [15:0]            pc, vec;
	logic [3:0]             rank;
	logic [7:0]             en_r, lvl_r, aux_r;
	int                     n_errors = 0;
	int                     num_checks = 0;
	localparam logic [14:0] MSK [11] = '{15'h4000, 15'h2000, 15'h1000, 15'h0c00, 15'h0200,
		15'h0100, 15'h0080, 15'h0060, 15'h0018, 15'h0006, 15'h0001};
	localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b,
		16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};

	tlip_prioritizer u_tlip_prioritizer (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req),
		.watchdog_irq_select_i(wsel), .watchdog_timeout_nz_i(wnz), .sfr_wr_i(sfr),
		.core_ack_i(ack), .reti_i(reti_i), .pc_i(pc), .push_o(push), .push_pc_o(),
		.vector_load_o(load), .vector_o(vec), .src_rank_o(rank), .active_high_o(act_hi),
		.active_low_o(act_lo), .irq_enable_reg_o(en_r), .irq_level_reg_o(lvl_r),
		.aux_irq_reg_o(aux_r));
	tlip_core_model u_tlip_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .push_i(push),
		.vector_load_i(load), .vector_i(vec), .ack_delay_i(dly), .core_ack_o(ack), .pc_o(pc));

	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr <= '{we: 1'b1, addr: a, data: d};
		@(posedge clk_i);
		sfr <= '0;
		// Let an edge pass so back-to-back writes never assign sfr twice in one step
		@(posedge clk_i);
	endtask : wr
	task automatic quiet(input string msg);
		repeat (20) begin
			@(negedge clk_i);
			chk(push === 1'b0, msg);
		end
		@(posedge clk_i);
	endtask : quiet
	task automatic leave;
		@(posedge clk_i);
		reti_i <= 1'b1;
		@(posedge clk_i);
		reti_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : leave
	// Waits for the jump, checks where it goes and at which level, then clears the flag
	task automatic serve(input int r, input logic hi);
		int i;
		i = 0;
		do begin
			@(negedge clk_i);
			i++;
		end while (load !== 1'b1 && i < 60);
		if (load !== 1'b1) begin
			n_errors++;
			complete_run();
		end
		chk(vec === VEC[r] && rank === 4'(r), "vector");
		repeat (2) @(negedge clk_i);
		chk(act_hi === hi && (act_lo | hi) === 1'b1, "level");
		@(posedge clk_i);
		req <= req & ~MSK[r];
	endtask : serve
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		chk(en_r === 8'h00 && lvl_r === 8'h00 && aux_r === 8'ha0, "reset");
		@(posedge clk_i);
		wr(8'ha8, 8'hff);
		wr(8'hb8, 8'hff);
		wr(8'ha9, 8'hff);
		wr(8'haa, 8'h00);
		repeat (2) @(negedge clk_i);
		chk(en_r === 8'hff && lvl_r === 8'h7f && aux_r === 8'hf7, "write");
		@(posedge clk_i);
		wr(8'hb8, 8'h00);
		wr(8'ha9, 8'h07);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_sweep(input logic all);
		if (all) req <= 15'h5fff;
		for (int r = 0; r < 11; r++) begin
			if (r != 1) begin
				if (!all) req <= MSK[r] & ~(MSK[r] - 15'h1);
				dly <= 4'(r);
				serve(r, 1'b0);
				leave();
			end
		end
		$display("t_sweep done");
	endtask : t_sweep
	task automatic t_mask;
		wr(8'ha8, 8'h00);
		req <= 15'h3000;
		wsel <= 1'b1;
		quiet("zero timeout");
		wsel <= 1'b0;
		wnz <= 1'b1;
		quiet("select off");
		wsel <= 1'b1;
		serve(1, 1'b1);
		leave();
		wr(8'ha8, 8'h01);
		quiet("gate off");
		wr(8'ha8, 8'h80);
		quiet("source off");
		wr(8'ha8, 8'h81);
		serve(2, 1'b0);
		leave();
		$display("t_mask done");
	endtask : t_mask
	task automatic t_nest;
		wr(8'ha8, 8'h8f);
		wr(8'hb8, 8'h08);
		req <= 15'h1080;
		serve(6, 1'b1);
		leave();
		serve(2, 1'b0);
		@(posedge clk_i);
		req <= 15'h0100;
		quiet("same level");
		req <= 15'h0180;
		serve(6, 1'b1);
		leave();
		quiet("low still busy");
		leave();
		serve(5, 1'b0);
		leave();
		wr(8'ha9, 8'h47);
		req <= 15'h1001;
		serve(10, 1'b1);
		leave();
		serve(2, 1'b0);
		leave();
		$display("t_nest done");
	endtask : t_nest
	task automatic complete_run;
		$display("Checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		t_reset();
		t_sweep(1'b1);
		t_sweep(1'b0);
		t_mask();
		t_nest();
		complete_run();
	end
endmodule : test_tlip_prioritizer

// *** testbench/tlip_core_model.sv ***
`timescale 1ns/1ps
module tlip_core_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Controller side
	input  wire logic        push_i,
	input  wire logic        vector_load_i,
	input  wire logic [15:0] vector_i,
	input  wire logic [3:0]  ack_delay_i,
	output logic             core_ack_o,
	output logic [15:0]      pc_o
);
	logic [3:0] wait_cnt;
	// Stack write takes a chosen number of cycles, so slow cores are covered
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !push_i || core_ack_o) begin
			core_ack_o <= 1'b0;
			wait_cnt   <= 4'h0;
		end else if (wait_cnt == ack_delay_i) begin
			core_ack_o <= 1'b1;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pc_o <= 16'h0100;
		end else if (vector_load_i) begin
			pc_o <= vector_i;
		end else begin
			pc_o <= pc_o + 16'h0001;
		end
	end
endmodule : tlip_core_model

// *** testbench/tlip_prioritizer_monitor.sv ***
`timescale 1ns/1ps
module tlip_prioritizer_monitor (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// Core side
	input wire logic        core_ack_i,
	input wire logic        reti_i,
	input wire logic [15:0] pc_i,
	// Controller outputs
	input wire logic        push_o,
	input wire logic [15:0] push_pc_o,
	input wire logic        vector_load_o,
	input wire logic [15:0] vector_o,
	input wire logic [3:0]  src_rank_o,
	input wire logic        active_high_o,
	input wire logic        active_low_o,
	input wire logic [7:0]  aux_irq_reg_o
);
	localparam logic [15:0] VEC [11] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b,
		16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_hold; push_o && !core_ack_i |=> push_o; endproperty
	a_hold: assert property (p_hold) else $error("push dropped early");
	property p_load; push_o && core_ack_i |=> vector_load_o && !push_o; endproperty
	a_load: assert property (p_load) else $error("no vector load");
	property p_pc; $rose(push_o) |-> push_pc_o == $past(pc_i); endproperty
	a_pc: assert property (p_pc) else $error("bad pushed pc");
	property p_vec; push_o |-> vector_o == VEC[src_rank_o]; endproperty
	a_vec: assert property (p_vec) else $error("vector mismatch");
	property p_stable; push_o |=> $stable(vector_o); endproperty
	a_stable: assert property (p_stable) else $error("vector moved");
	property p_mark; vector_load_o |-> ##2 (active_high_o || active_low_o); endproperty
	a_mark: assert property (p_mark) else $error("level not marked");
	property p_same; $rose(push_o) && !$past(reti_i) && !$past(reti_i, 2) |-> !active_high_o;
	endproperty
	a_same: assert property (p_same) else $error("dispatch under high");
	property p_rel; reti_i && active_high_o && !active_low_o && !push_o && !vector_load_o
		|-> ##2 !active_high_o; endproperty
	a_rel: assert property (p_rel) else $error("level not released");
	property p_aux; aux_irq_reg_o[7] && !aux_irq_reg_o[3]; endproperty
	a_aux: assert property (p_aux) else $error("aux fixed bits");
endmodule : tlip_prioritizer_monitor

bind tlip_prioritizer tlip_prioritizer_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.core_ack_i(core_ack_i), .reti_i(reti_i), .pc_i(pc_i), .push_o(push_o),
	.push_pc_o(push_pc_o), .vector_load_o(vector_load_o), .vector_o(vector_o),
	.src_rank_o(src_rank_o), .active_high_o(active_high_o), .active_low_o(active_low_o),
	.aux_irq_reg_o(aux_irq_reg_o));
